// ---- rtl/slc_pkg.sv ----
// Functional notes
// - Writing one to start bit 4 begins a measurement; the bit self-clears.
// - Done flag, bit 7, sets once the count of sixteen periods finishes.
// - Counter is 20 bits; bits 19 to 16 read in bits 3 to 0.
// - Each count is one 50 ns tick of the main clock.
// - Measured period follows the currently selected source and divisor.
// - Sleep clock is the selected source divided by two to the divisor.
// - Radio state code reads in bits 7 to 5; bits 4 to 0 read zero.
`default_nettype none
package slc_pkg;
    // Register offsets
    localparam logic [11:0] ADDR_SRC_SEL   = 12'h207;
    localparam logic [11:0] ADDR_CAL_CTRL  = 12'h20b;
    localparam logic [11:0] ADDR_RADIO     = 12'h20f;
    localparam logic [11:0] ADDR_DIVISOR   = 12'h220;
    localparam logic [11:0] ADDR_IRQ_STAT  = 12'h240;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h241;
    // Field positions
    localparam int BIT_DONE       = 7;
    localparam int BIT_START      = 4;
    localparam int SEL_LSB        = 6;
    localparam int RADIO_LSB      = 5;
    localparam int IRQ_DONE_BIT   = 0;
    // Widths and reset values
    localparam int ADDR_W         = 12;
    localparam int DATA_W         = 8;
    localparam int COUNT_W        = 20;
    localparam int DIV_W          = 5;
    localparam int SEL_W          = 2;
    localparam int SRC_N          = 4;
    localparam int DIV_CNT_W      = 32;
    localparam int PER_W          = 4;
    localparam logic [PER_W-1:0] CAL_LAST_PERIOD = 4'hf;
    localparam logic [DIV_W-1:0] DIVISOR_RESET   = 5'h00;
    localparam logic [SEL_W-1:0] SEL_RESET       = 2'h0;
    // Timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TICK_NS        = 50;
    localparam int ACC_W          = 7;
    // Radio state codes
    typedef enum logic [2:0] {
        RS_RESET      = 3'h0,
        RS_FILTER_CAL = 3'h1,
        RS_SLEEP      = 3'h2,
        RS_OSC_CAL    = 3'h3,
        RS_TX         = 3'h4,
        RS_RX         = 3'h5,
        RS_RETAIN_ONE = 3'h6,
        RS_RETAIN_TWO = 3'h7
    } slc_radio_e;
    // Calibration states
    typedef enum logic [3:0] {
        CS_IDLE  = 4'h1,
        CS_ALIGN = 4'h2,
        CS_COUNT = 4'h4,
        CS_DONE  = 4'h8
    } slc_cal_e;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } slc_bus_s;
endpackage
`default_nettype wire

// ---- rtl/slc_tick_gen.sv ----
`default_nettype none
// Fractional divider: 50 ns is not a whole number of 8 ns cycles, so ticks
// come every 6 or 7 cycles and average out exactly.
module slc_tick_gen #(
    parameter int CLK_NS  = slc_pkg::CLK_PERIOD_NS,
    parameter int TICK_NS = slc_pkg::TICK_NS
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    localparam int                        AW    = slc_pkg::ACC_W;
    localparam logic [AW-1:0]             STEP  = AW'(CLK_NS);
    localparam logic [AW-1:0]             LIMIT = AW'(TICK_NS);

    logic [slc_pkg::ACC_W-1:0] acc_reg;
    logic [slc_pkg::ACC_W-1:0] acc_sum;
    logic                      tick_reg;

    assign acc_sum = acc_reg + STEP;
    assign tick_o  = tick_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                acc_reg  <= '0;
                tick_reg <= 1'b0;
            end else if (acc_sum >= LIMIT) begin
                acc_reg  <= acc_sum - LIMIT;
                tick_reg <= 1'b1;
            end else begin
                acc_reg  <= acc_sum;
                tick_reg <= 1'b0;
            end
        end
    end

    tick_spacing_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (tick_reg && ce_i) |=> !tick_reg)
        else $error("tick pulses back to back");
endmodule
`default_nettype wire

// ---- rtl/slc_lp_div.sv ----
`default_nettype none
// Divides rising edges of the selected source by two to the divisor
module slc_lp_div #(
    parameter int DW = slc_pkg::DIV_W,
    parameter int CW = slc_pkg::DIV_CNT_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ce_i,
    input  wire logic          clr_i,
    input  wire logic          rise_i,
    input  wire logic [DW-1:0] div_i,
    output logic               edge_o
);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] mask;

    assign mask   = (CW'(1) << div_i) - CW'(1);
    assign edge_o = rise_i && !clr_i && (cnt_reg == mask);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (ce_i) begin
            if (clr_i || edge_o) begin
                cnt_reg <= '0;
            end else if (rise_i) begin
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end

    undivided_edge_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && rise_i && !clr_i && div_i == '0) |-> edge_o)
        else $error("divisor zero must pass every source edge");
endmodule
`default_nettype wire

// ---- rtl/slc_top.sv ----
// Added by the designer: strobed register access.
`default_nettype none
module slc_top (
    // Clock, reset, enable
    input  wire logic                         MCLK_I,
    input  wire logic                         RST_N_I,
    input  wire logic                         CE_I,
    // Register port
    input  wire logic [slc_pkg::ADDR_W-1:0]   REG_ADDR_I,
    input  wire logic [slc_pkg::DATA_W-1:0]   REG_WDATA_I,
    input  wire logic                         REG_WR_I,
    input  wire logic                         REG_RD_I,
    output logic      [slc_pkg::DATA_W-1:0]   REG_RDATA_O,
    // Low-power clock sources and radio state
    input  wire logic [slc_pkg::SRC_N-1:0]    LP_SRC_I,
    input  wire logic [2:0]                   RADIO_STATE_I,
    // Status
    output logic                              CAL_DONE_O,
    output logic                              IRQ_O
);
    slc_pkg::slc_bus_s                     bus;
    slc_pkg::slc_cal_e                     state_reg;
    slc_pkg::slc_cal_e                     state_next;

    logic [slc_pkg::COUNT_W-1:0]           count_reg;
    logic [slc_pkg::PER_W-1:0]             per_reg;
    logic                                  done_reg;
    logic                                  start_reg;
    logic [slc_pkg::SEL_W-1:0]             sel_reg;
    logic [slc_pkg::DIV_W-1:0]             div_reg;
    logic [slc_pkg::SRC_N-1:0]             src_prev_reg;
    logic [slc_pkg::DATA_W-1:0]            irq_stat_reg;
    logic [slc_pkg::DATA_W-1:0]            irq_mask_reg;
    logic [slc_pkg::DATA_W-1:0]            rdata_reg;
    logic [slc_pkg::DATA_W-1:0]            rdata_next;
    logic [slc_pkg::DATA_W-1:0]            irq_event;

    logic                                  start_w;
    logic                                  src_rise;
    logic                                  sleep_edge;
    logic                                  tick;
    logic                                  tick_clr;
    logic                                  finish_w;

    function automatic logic hit(input logic [slc_pkg::ADDR_W-1:0] a,
                                 input logic [slc_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    assign bus = '{addr:  REG_ADDR_I,
                   wdata: REG_WDATA_I,
                   wr:    REG_WR_I,
                   rd:    REG_RD_I};

    // Reserved bits 6:5 are ignored on write; software is expected to keep them zero
    assign start_w = bus.wr && hit(bus.addr, slc_pkg::ADDR_CAL_CTRL)
                     && bus.wdata[slc_pkg::BIT_START];

    // A source switch mid-run fakes no edge but mixes two sources in one period; restart after reconfiguring
    assign src_rise = LP_SRC_I[sel_reg] && !src_prev_reg[sel_reg];

    assign finish_w = (state_reg == slc_pkg::CS_COUNT) && sleep_edge
                      && (per_reg == slc_pkg::CAL_LAST_PERIOD);

    assign tick_clr = start_w || ((state_reg == slc_pkg::CS_ALIGN) && sleep_edge);

    slc_lp_div u_div (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .clr_i   (start_w),
        .rise_i  (src_rise),
        .div_i   (div_reg),
        .edge_o  (sleep_edge)
    );

    slc_tick_gen u_tick (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .clr_i   (tick_clr),
        .tick_o  (tick)
    );

    // Source history for edge detection
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            src_prev_reg <= '0;
        end else if (CE_I) begin
            src_prev_reg <= LP_SRC_I;
        end
    end

    // Configuration registers
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            sel_reg <= slc_pkg::SEL_RESET;
            div_reg <= slc_pkg::DIVISOR_RESET;
        end else if (CE_I && bus.wr) begin
            if (hit(bus.addr, slc_pkg::ADDR_SRC_SEL)) begin
                sel_reg <= bus.wdata[slc_pkg::SEL_LSB +: slc_pkg::SEL_W];
            end
            if (hit(bus.addr, slc_pkg::ADDR_DIVISOR)) begin
                div_reg <= bus.wdata[slc_pkg::DIV_W-1:0];
            end
        end
    end

    // Start bit lives one cycle only
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            start_reg <= 1'b0;
        end else if (CE_I) begin
            start_reg <= start_w;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            slc_pkg::CS_IDLE: begin
                state_next = slc_pkg::CS_IDLE;
            end
            slc_pkg::CS_ALIGN: begin
                if (sleep_edge) begin
                    state_next = slc_pkg::CS_COUNT;
                end
            end
            slc_pkg::CS_COUNT: begin
                if (finish_w) begin
                    state_next = slc_pkg::CS_DONE;
                end
            end
            slc_pkg::CS_DONE: begin
                state_next = slc_pkg::CS_DONE;
            end
            default: begin
                state_next = slc_pkg::CS_IDLE;
            end
        endcase
        if (start_w) begin
            state_next = slc_pkg::CS_ALIGN;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state_reg <= slc_pkg::CS_IDLE;
        end else if (CE_I) begin
            state_reg <= state_next;
        end
    end

    // Tick counter and period counter
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            count_reg <= '0;
            per_reg   <= '0;
        end else if (CE_I) begin
            if (start_w) begin
                count_reg <= '0;
                per_reg   <= '0;
            end else if (state_reg == slc_pkg::CS_COUNT) begin
                // Saturate rather than wrap so an overlong period reads as full scale
                if (tick && count_reg != '1) begin
                    count_reg <= count_reg + {{(slc_pkg::COUNT_W-1){1'b0}}, 1'b1};
                end
                if (sleep_edge) begin
                    per_reg <= per_reg + {{(slc_pkg::PER_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Restart wins over a finish in the same cycle, dropping the stale result
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            done_reg <= 1'b0;
        end else if (CE_I) begin
            if (start_w) begin
                done_reg <= 1'b0;
            end else if (finish_w) begin
                done_reg <= 1'b1;
            end
        end
    end

    // Interrupt status: write one to clear, a new event wins
    always_comb begin
        irq_event = '0;
        irq_event[slc_pkg::IRQ_DONE_BIT] = finish_w;
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end else if (CE_I) begin
            if (bus.wr && hit(bus.addr, slc_pkg::ADDR_IRQ_STAT)) begin
                irq_stat_reg <= (irq_stat_reg & ~bus.wdata) | irq_event;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_event;
            end
            if (bus.wr && hit(bus.addr, slc_pkg::ADDR_IRQ_MASK)) begin
                irq_mask_reg <= bus.wdata;
            end
        end
    end

    // Read mux; unmapped addresses return zero
    always_comb begin
        rdata_next = '0;
        case (bus.addr)
            slc_pkg::ADDR_SRC_SEL: begin
                rdata_next[slc_pkg::SEL_LSB +: slc_pkg::SEL_W] = sel_reg;
            end
            slc_pkg::ADDR_CAL_CTRL: begin
                rdata_next[slc_pkg::BIT_DONE]  = done_reg;
                rdata_next[slc_pkg::BIT_START] = start_reg;
                rdata_next[3:0] = count_reg[slc_pkg::COUNT_W-1 -: 4];
            end
            slc_pkg::ADDR_RADIO: begin
                rdata_next[slc_pkg::RADIO_LSB +: 3] = RADIO_STATE_I;
            end
            slc_pkg::ADDR_DIVISOR: begin
                rdata_next[slc_pkg::DIV_W-1:0] = div_reg;
            end
            slc_pkg::ADDR_IRQ_STAT: begin
                rdata_next = irq_stat_reg;
            end
            slc_pkg::ADDR_IRQ_MASK: begin
                rdata_next = irq_mask_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= '0;
        end else if (CE_I) begin
            rdata_reg <= bus.rd ? rdata_next : '0;
        end
    end

    assign REG_RDATA_O = rdata_reg;
    assign CAL_DONE_O  = done_reg;
    assign IRQ_O       = |(irq_stat_reg & irq_mask_reg);

    sequence start_seq;
        CE_I && start_w;
    endsequence

    sequence last_edge_seq;
        CE_I && !start_w && finish_w;
    endsequence

    start_self_clear_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        start_seq |=> start_reg ##1 (!start_reg || $past(!CE_I || start_w)))
        else $error("start bit did not self clear");

    done_set_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        last_edge_seq |=> done_reg && CAL_DONE_O && state_reg == slc_pkg::CS_DONE)
        else $error("done flag not set at end of count");

    upper_readback_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && bus.rd && bus.addr == slc_pkg::ADDR_CAL_CTRL)
        |=> REG_RDATA_O[3:0] == $past(count_reg[19:16])
            && REG_RDATA_O[6:5] == 2'h0)
        else $error("upper count bits misplaced");

    tick_count_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && !start_w && state_reg == slc_pkg::CS_COUNT && !tick)
        |=> count_reg == $past(count_reg))
        else $error("count moved without a tick");

    source_edge_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        sleep_edge |-> LP_SRC_I[sel_reg] && !src_prev_reg[sel_reg])
        else $error("sleep edge without selected source rise");

    radio_read_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && bus.rd && bus.addr == slc_pkg::ADDR_RADIO)
        |=> REG_RDATA_O == {$past(RADIO_STATE_I), 5'h00})
        else $error("radio state readback wrong");

    restart_clear_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        start_seq |=> !done_reg && count_reg == '0 && state_reg == slc_pkg::CS_ALIGN)
        else $error("start did not clear done and count");

    done_hold_a: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (done_reg && !start_w) |=> done_reg && $stable(count_reg))
        else $error("result changed without a new start");
endmodule
`default_nettype wire

// ---- tb/test_sleep_clock_calibration.sv ----
`default_nettype none
module test_sleep_clock_calibration;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        string      name;
        logic [7:0] value;
    } slc_exp_s;

    logic        mclk        = 1'b0;
    logic        rst_n       = 1'b0;
    logic        ce          = 1'b1;
    logic [11:0] reg_addr    = 12'h000;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [7:0]  reg_rdata;
    logic [3:0]  lp_src      = 4'h0;
    logic [2:0]  radio_state = 3'h0;
    logic        cal_done;
    logic        irq;
    logic        rd_d        = 1'b0;
    logic        done_s      = 1'b0;
    logic        irq_s       = 1'b0;
    logic [7:0]  d;
    int          n_errors        = 0;
    int          samples_checked = 0;
    int          seed_v;
    slc_exp_s    exp_q[$];
    slc_exp_s    cur_e;
    int          div_t[4]  = '{0, 1, 5, 2};
    logic [11:0] map_a[7]  = '{slc_pkg::ADDR_SRC_SEL, slc_pkg::ADDR_CAL_CTRL,
                               slc_pkg::ADDR_RADIO, slc_pkg::ADDR_DIVISOR,
                               slc_pkg::ADDR_IRQ_STAT, slc_pkg::ADDR_IRQ_MASK, 12'h300};

    always #4 mclk = ~mclk;

    slc_top u_slc_top (
        .MCLK_I        (mclk),
        .RST_N_I       (rst_n),
        .CE_I          (ce),
        .REG_ADDR_I    (reg_addr),
        .REG_WDATA_I   (reg_wdata),
        .REG_WR_I      (reg_wr),
        .REG_RD_I      (reg_rd),
        .REG_RDATA_O   (reg_rdata),
        .LP_SRC_I      (lp_src),
        .RADIO_STATE_I (radio_state),
        .CAL_DONE_O    (cal_done),
        .IRQ_O         (irq)
    );

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge mclk) rd_d <= reg_rd && ce && rst_n;
    always @(negedge mclk) begin
        done_s = cal_done;
        irq_s = irq;
        if (rd_d) begin
            cur_e = exp_q.pop_front();
            chk(cur_e.name, cur_e.value, reg_rdata);
        end
    end

    // Each call assigns every bus signal once, so calls may follow back to back
    task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] v);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        acc(1'b1, 1'b0, a, v);
    endtask

    task automatic rd(input string name, input logic [11:0] a, input logic [7:0] e);
        slc_exp_s x;
        x.name = name;
        x.value = e;
        exp_q.push_back(x);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle;
        acc(1'b0, 1'b0, 12'h000, 8'h00);
    endtask

    // Unselected sources toggle at random to catch a wrong selection
    task automatic src_cycles(input int sel, input logic v, input int k);
        logic [3:0] r;
        repeat (k) begin
            r = 4'($urandom);
            r[sel] = v;
            lp_src <= r;
            @(posedge mclk);
        end
    endtask

    task automatic cal_run(input int sel, input int n, input int per, input bit restart);
        int total;
        total = 17 << n;
        lp_src <= 4'h0;
        wr(slc_pkg::ADDR_SRC_SEL, 8'(sel << slc_pkg::SEL_LSB));
        wr(slc_pkg::ADDR_DIVISOR, 8'(n));
        wr(slc_pkg::ADDR_CAL_CTRL, 8'h10);
        rd("start readback", slc_pkg::ADDR_CAL_CTRL, 8'h10);
        rd("start cleared", slc_pkg::ADDR_CAL_CTRL, 8'h00);
        idle();
        if (restart) begin
            repeat (5) begin
                src_cycles(sel, 1'b1, per / 2);
                src_cycles(sel, 1'b0, per / 2);
            end
            wr(slc_pkg::ADDR_CAL_CTRL, 8'h10);
            idle();
        end
        for (int i = 0; i < total; i++) begin
            chk("done early", 8'h00, {7'h00, done_s});
            src_cycles(sel, 1'b1, per / 2);
            src_cycles(sel, 1'b0, per / 2);
        end
        chk("done flag", 8'h01, {7'h00, done_s});
        // Short runs keep the count far below 0x10000, so the upper nibble is zero
        rd("cal status", slc_pkg::ADDR_CAL_CTRL, 8'h80);
        idle();
        src_cycles(sel, 1'b1, per);
        src_cycles(sel, 1'b0, per);
        chk("done held", 8'h01, {7'h00, done_s});
    endtask

    initial begin
        seed_v = $urandom(32'hddfb);
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        foreach (map_a[i]) begin
            rd("reset value", map_a[i], 8'h00);
        end
        idle();
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(slc_pkg::ADDR_SRC_SEL, d);
            rd("source select", slc_pkg::ADDR_SRC_SEL, d & 8'hc0);
            wr(slc_pkg::ADDR_DIVISOR, d);
            rd("divisor", slc_pkg::ADDR_DIVISOR, d & 8'h1f);
            wr(12'h300, d);
            rd("unmapped", 12'h300, 8'h00);
            wr(slc_pkg::ADDR_RADIO, d);
        end
        for (int c = 0; c < 8; c++) begin
            radio_state <= 3'(c);
            rd("radio state", slc_pkg::ADDR_RADIO, {3'(c), 5'h00});
        end
        idle();
        $display("test register access done");
        wr(slc_pkg::ADDR_DIVISOR, 8'h03);
        ce <= 1'b0;
        wr(slc_pkg::ADDR_DIVISOR, 8'h1c);
        idle();
        ce <= 1'b1;
        rd("enable hold", slc_pkg::ADDR_DIVISOR, 8'h03);
        idle();
        $display("test clock enable done");
        for (int i = 0; i < 4; i++) begin
            cal_run(i, div_t[i], 4 + 2 * int'($urandom_range(3)), i == 2);
            if (i == 0) begin
                chk("irq masked", 8'h00, {7'h00, irq_s});
                rd("irq status", slc_pkg::ADDR_IRQ_STAT, 8'h01);
                wr(slc_pkg::ADDR_IRQ_MASK, 8'h01);
                idle();
                chk("irq unmasked", 8'h01, {7'h00, irq_s});
            end else begin
                chk("irq raised", 8'h01, {7'h00, irq_s});
            end
            wr(slc_pkg::ADDR_IRQ_STAT, 8'h01);
            idle();
            chk("irq cleared", 8'h00, {7'h00, irq_s});
            rd("irq status clear", slc_pkg::ADDR_IRQ_STAT, 8'h00);
            idle();
            $display("test calibration %0d done", i);
        end
        stop_test();
    end

    // Longest run is a few thousand cycles; this limit leaves ample margin
    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        stop_test();
    end
endmodule
`default_nettype wire
